/* File: rtl/atl_pkg.sv */
// Notes on behaviour
// - Auto-trigger pulses are spaced 1 + fixed delay + random 1..2^spread cycles.
// - Each counted interval cycle is one 3.2 ns acquisition clock period.
// - Auto-trigger output is offered as a trigger source for periodic or random acquisition.
// - A timestamp packet is made when any masked trigger source fires.
// - Every timestamp packet is exactly 16 bytes long.
// - Second packet word holds 32-bit source level snapshot, period monitor excluded.
// - Simultaneous firing sources yield exactly one packet.
// - With lookup enabled, each sample is replaced by its 1024-word table entry.
// - Nonlinearity correction is applied first, then the corrected sample indexes the table.
// - Auto-trigger is ORed into trig_out whenever auto-trigger is enabled, outside the trigger mask; the timestamp mask does not include it.
package atl_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam real ACQ_PERIOD_NS = 3.2;
	localparam int  PKT_BYTES     = 16;
	localparam int  PKT_WORDS     = PKT_BYTES / 4;
	localparam int  LUT_DEPTH     = 1024;
	localparam int  SAMPLE_W      = 10;
	localparam int  SRC_W         = 32;
	localparam int  TS_W          = 48;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_FIXED_DLY  = 8'h04;
	localparam logic [7:0] REG_SPREAD     = 8'h08;
	localparam logic [7:0] REG_TS_MASK    = 8'h0c;
	localparam logic [7:0] REG_TRIG_MASK  = 8'h10;
	localparam logic [7:0] REG_LUT_ADDR   = 8'h14;
	localparam logic [7:0] REG_LUT_DATA   = 8'h18;
	localparam logic [7:0] REG_STATUS     = 8'h1c;
	localparam logic [7:0] REG_INL_OFS    = 8'h20;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CTRL_AUTO_EN_BIT = 0;
	localparam int CTRL_LUT_EN_BIT  = 1;
	localparam int CTRL_TS_EN_BIT   = 2;
	localparam int CTRL_W           = 3;
	localparam int SPREAD_W         = 5;
	localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
	localparam logic [SPREAD_W-1:0] SPREAD_MAX = 5'h10;
	localparam logic [31:0] LFSR_SEED  = 32'h0000_0001;
	localparam logic [31:0] LFSR_TAPS  = 32'h8020_0003;
	localparam logic [31:0] ID_VALUE   = 32'h00a5_0001; // Arbitrary value

	// ------------------------------------------------------------
	// Packet header word
	// ------------------------------------------------------------
	localparam logic [7:0] PKT_TYPE_TS = 8'h5a;

	typedef enum logic [1:0] {
		TS_IDLE = 2'b01,
		TS_SEND = 2'b10
	} atl_ts_state_t;

endpackage

/* File: rtl/atl_lut.sv */
`timescale 1ns/1ps
module atl_lut
	import atl_pkg::*;
#(
	parameter int DEPTH  = LUT_DEPTH,
	parameter int DATA_W = 16
) (
	// Clock
	input  wire logic                     ref_clk,
	// Table load
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [DATA_W-1:0]        wr_data,
	// Lookup
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic      [DATA_W-1:0]        rd_data
);

	if (DEPTH < 2) begin
		$error("atl_lut: DEPTH too small");
	end

	logic [DATA_W-1:0] mem [DEPTH];

	// Table contents are undefined until software loads all entries
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule

/* File: rtl/atl_top.sv */
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module atl_top
	import atl_pkg::*;
#(
	parameter int NSRC   = SRC_W,
	parameter int OUT_W  = 16
) (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                sys_rst,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [31:0]         reg_rdata,
	// Trigger matrix side
	input  wire logic [NSRC-1:0]     src_level,
	input  wire logic [NSRC-1:0]     src_fire,
	input  wire logic                period_mon,
	output logic                     auto_trig,
	output logic                     trig_out,
	// Sample path
	input  wire logic                smp_valid,
	input  wire logic [SAMPLE_W-1:0] smp_data,
	output logic                     smp_out_valid,
	output logic      [OUT_W-1:0]    smp_out_data,
	// Timestamp stream
	output logic                     ts_valid,
	output logic      [31:0]         ts_data,
	output logic                     ts_last
);

	if (NSRC != SRC_W) begin
		$error("atl_top: NSRC must equal packet snapshot width");
	end
	if (OUT_W > 32 || OUT_W < SAMPLE_W) begin
		$error("atl_top: bad OUT_W");
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [CTRL_W-1:0]   ctrl_r;
	logic [31:0]         fixed_dly_r;
	logic [SPREAD_W-1:0] spread_r;
	logic [NSRC-1:0]     ts_mask_r;
	logic [NSRC-1:0]     trig_mask_r;
	logic [SAMPLE_W-1:0] lut_addr_r;
	logic [SAMPLE_W-1:0] inl_ofs_r;
	logic [31:0]         ts_count_r;

	wire wr_ctrl  = reg_wr && reg_addr == REG_CTRL;
	wire wr_fixed = reg_wr && reg_addr == REG_FIXED_DLY;
	wire wr_sprd  = reg_wr && reg_addr == REG_SPREAD;
	wire wr_tsm   = reg_wr && reg_addr == REG_TS_MASK;
	wire wr_trm   = reg_wr && reg_addr == REG_TRIG_MASK;
	wire wr_laddr = reg_wr && reg_addr == REG_LUT_ADDR;
	wire wr_ldata = reg_wr && reg_addr == REG_LUT_DATA;
	wire wr_inl   = reg_wr && reg_addr == REG_INL_OFS;

	wire auto_en = ctrl_r[CTRL_AUTO_EN_BIT];
	wire lut_en  = ctrl_r[CTRL_LUT_EN_BIT];
	wire ts_en   = ctrl_r[CTRL_TS_EN_BIT];

	wire [SPREAD_W-1:0] spread_clip = (wr_sprd && reg_wdata[SPREAD_W-1:0] > SPREAD_MAX) ?
		SPREAD_MAX : reg_wdata[SPREAD_W-1:0];

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r      <= '0;
			fixed_dly_r <= RST_ZERO;
			spread_r    <= '0;
			ts_mask_r   <= '0;
			trig_mask_r <= '0;
			lut_addr_r  <= '0;
			inl_ofs_r   <= '0;
		end else begin
			if (wr_ctrl)  ctrl_r      <= reg_wdata[CTRL_W-1:0];
			if (wr_fixed) fixed_dly_r <= reg_wdata;
			if (wr_sprd)  spread_r    <= spread_clip;
			if (wr_tsm)   ts_mask_r   <= reg_wdata[NSRC-1:0];
			if (wr_trm)   trig_mask_r <= reg_wdata[NSRC-1:0];
			if (wr_inl)   inl_ofs_r   <= reg_wdata[SAMPLE_W-1:0];
			if (wr_laddr) begin
				lut_addr_r <= reg_wdata[SAMPLE_W-1:0];
			end else if (wr_ldata) begin
				lut_addr_r <= lut_addr_r + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr)
			REG_CTRL:      rd_mux = {{(32-CTRL_W){1'b0}}, ctrl_r};
			REG_FIXED_DLY: rd_mux = fixed_dly_r;
			REG_SPREAD:    rd_mux = {{(32-SPREAD_W){1'b0}}, spread_r};
			REG_TS_MASK:   rd_mux = ts_mask_r;
			REG_TRIG_MASK: rd_mux = trig_mask_r;
			REG_LUT_ADDR:  rd_mux = {{(32-SAMPLE_W){1'b0}}, lut_addr_r};
			REG_STATUS:    rd_mux = ts_count_r;
			REG_INL_OFS:   rd_mux = {{(32-SAMPLE_W){1'b0}}, inl_ofs_r};
			default:       rd_mux = '0;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) reg_rdata <= '0;
		else         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
	end

	// ------------------------------------------------------------
	// Auto-trigger generator
	// ------------------------------------------------------------
	logic [31:0] lfsr_r;
	logic [32:0] gap_cnt_r;
	logic [32:0] gap_nxt;
	logic        auto_pulse;

	// Mask keeps spread bits, so value spans 0..2^N-1; plus one gives 1..2^N
	wire [31:0] spread_mask = (32'h0000_0001 << spread_r) - 32'h0000_0001;
	wire [32:0] rnd_part    = {1'b0, lfsr_r & spread_mask} + 33'h1;
	// Interval = 1 + M + rnd; counter reloads with M + rnd, pulse on expiry
	assign gap_nxt    = {1'b0, fixed_dly_r} + rnd_part;
	assign auto_pulse = auto_en && gap_cnt_r == '0;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lfsr_r    <= LFSR_SEED;
			gap_cnt_r <= '0;
		end else begin
			lfsr_r <= {lfsr_r[30:0], ^(lfsr_r & LFSR_TAPS)};
			if (!auto_en)        gap_cnt_r <= '0;
			else if (auto_pulse) gap_cnt_r <= gap_nxt;
			else                 gap_cnt_r <= gap_cnt_r - 33'h1;
		end
	end

	// ------------------------------------------------------------
	// Trigger source mask: auto-trigger as extra input
	// ------------------------------------------------------------
	wire trig_any = |(src_fire & trig_mask_r) || (auto_pulse && ctrl_r[CTRL_AUTO_EN_BIT]);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			auto_trig <= 1'b0;
			trig_out  <= 1'b0;
		end else begin
			auto_trig <= auto_pulse;
			trig_out  <= trig_any;
		end
	end

	// ------------------------------------------------------------
	// Timestamp channel
	// ------------------------------------------------------------
	logic [TS_W-1:0] time_r;
	atl_ts_state_t   ts_st_r;
	logic [1:0]      word_r;
	logic [TS_W-1:0] ev_time_r;
	logic [31:0]     ev_lvl_r;

	wire ts_hit = ts_en && |(src_fire & ts_mask_r);
	// Snapshot of source levels; period monitor is a separate input and not included
	wire [31:0] lvl_snap = src_level;

	logic [31:0] ts_word;
	always_comb begin
		case (word_r)
			2'd0:    ts_word = {PKT_TYPE_TS, 24'h00_0000};
			2'd1:    ts_word = ev_lvl_r;
			2'd2:    ts_word = ev_time_r[31:0];
			default: ts_word = {16'h0000, ev_time_r[TS_W-1:32]};
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			time_r     <= '0;
			ts_st_r    <= TS_IDLE;
			word_r     <= '0;
			ev_time_r  <= '0;
			ev_lvl_r   <= '0;
			ts_count_r <= '0;
			ts_valid   <= 1'b0;
			ts_data    <= '0;
			ts_last    <= 1'b0;
		end else begin
			time_r   <= time_r + 1'b1;
			ts_valid <= 1'b0;
			ts_last  <= 1'b0;
			case (ts_st_r)
				TS_IDLE: begin
					// One packet per event, however many sources fired
					if (ts_hit) begin
						ev_time_r  <= time_r;
						ev_lvl_r   <= lvl_snap;
						word_r     <= '0;
						ts_count_r <= ts_count_r + 1'b1;
						ts_st_r    <= TS_SEND;
					end
				end
				TS_SEND: begin
					ts_valid <= 1'b1;
					ts_data  <= ts_word;
					ts_last  <= word_r == 2'(PKT_WORDS - 1);
					word_r   <= word_r + 1'b1;
					if (word_r == 2'(PKT_WORDS - 1)) ts_st_r <= TS_IDLE;
				end
				default: ts_st_r <= TS_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Sample path: correction then lookup
	// ------------------------------------------------------------
	logic [SAMPLE_W-1:0] corr_r;
	logic                corr_v_r;
	logic                lut_v_r;
	logic                lut_sel_r;
	logic [SAMPLE_W-1:0] corr_d_r;
	logic [OUT_W-1:0]    lut_q;

	// Offset correction stands in for the nonlinearity table
	wire [SAMPLE_W-1:0] corr_nxt = smp_data + inl_ofs_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			corr_r        <= '0;
			corr_v_r      <= 1'b0;
			lut_v_r       <= 1'b0;
			lut_sel_r     <= 1'b0;
			corr_d_r      <= '0;
			smp_out_valid <= 1'b0;
			smp_out_data  <= '0;
		end else begin
			corr_r        <= corr_nxt;
			corr_v_r      <= smp_valid;
			lut_v_r       <= corr_v_r;
			lut_sel_r     <= lut_en;
			corr_d_r      <= corr_r;
			smp_out_valid <= lut_v_r;
			smp_out_data  <= lut_sel_r ? lut_q : OUT_W'(corr_d_r);
		end
	end

	atl_lut #(
		.DEPTH  (LUT_DEPTH),
		.DATA_W (OUT_W)
	) u_lut (
		.ref_clk (ref_clk),
		.wr_en   (wr_ldata),
		.wr_addr (lut_addr_r),
		.wr_data (reg_wdata[OUT_W-1:0]),
		.rd_addr (corr_r),
		.rd_data (lut_q)
	);

endmodule

/* File: testbench/atl_assertions.sv */
`timescale 1ns/1ps
module atl_assertions
	import atl_pkg::*;
#(
	parameter int NSRC = SRC_W
) (
	// Clock and reset
	input wire logic            ref_clk,
	input wire logic            sys_rst,
	// Watched ports
	input wire logic [NSRC-1:0] src_level,
	input wire logic [NSRC-1:0] src_fire,
	input wire logic            auto_trig,
	input wire logic            smp_valid,
	input wire logic            smp_out_valid,
	input wire logic            ts_valid,
	input wire logic [31:0]     ts_data,
	input wire logic            ts_last
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	AST_TS_WORDS: assert property ($rose(ts_valid) |-> ts_valid[*4] ##1 !ts_valid)
		else $error("packet is not four words");
	AST_TS_LAST: assert property (ts_last |-> ts_valid && $past(ts_valid, 3))
		else $error("last flag misplaced");
	AST_TS_HDR: assert property ($rose(ts_valid) |-> ts_data == {PKT_TYPE_TS, 24'h0})
		else $error("header word wrong");
	AST_TS_SNAP: assert property ($rose(ts_valid) |=> ts_data == $past(src_level, 3))
		else $error("level snapshot wrong");
	AST_TS_HIT: assert property ($rose(ts_valid) |-> $past(|src_fire, 2))
		else $error("packet without a hit");
	AST_TS_ONE: assert property (ts_last |=> !ts_valid)
		else $error("packet follows too soon");
	AST_AUTO_GAP: assert property (auto_trig |=> !auto_trig)
		else $error("auto pulses too close");
	AST_SMP_LAT: assert property (smp_valid |-> ##3 smp_out_valid)
		else $error("sample latency wrong");
endmodule

bind atl_top atl_assertions #(.NSRC(NSRC)) atl_assertions_inst (.ref_clk, .sys_rst,
	.src_level, .src_fire, .auto_trig, .smp_valid, .smp_out_valid, .ts_valid, .ts_data, .ts_last);

/* File: testbench/atl_far_end.sv */
`timescale 1ns/1ps
module atl_far_end (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// Timestamp stream
	input wire logic        ts_valid,
	input wire logic [31:0] ts_data,
	input wire logic        ts_last,
	// Collected
	output int              n_words,
	output int              n_pkts,
	output logic     [31:0] snap
);
	int idx;
	// Host side never stalls the stream
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			n_words <= 0;
			n_pkts <= 0;
			idx <= 0;
			snap <= '0;
		end else if (ts_valid) begin
			n_words <= n_words + 1;
			idx <= ts_last ? 0 : idx + 1;
			if (idx == 1) snap <= ts_data;
			if (ts_last) n_pkts <= n_pkts + 1;
		end
	end
endmodule

/* File: testbench/test_aux_trigger_timestamp_lut.sv */
`timescale 1ns/1ps
module test_aux_trigger_timestamp_lut;
	import atl_pkg::*;
	logic        ref_clk, sys_rst, reg_wr, reg_rd, period_mon, auto_trig, trig_out;
	logic        smp_valid, smp_out_valid, ts_valid, ts_last;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, ts_data, src_level, src_fire, snap, v, lvl;
	logic [9:0]  smp_data;
	logic [15:0] smp_out_data, q[$];
	int          n_errors, n_checks, n_words, n_pkts, gap, na, nt;

	atl_top atl_top_inst (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .src_level, .src_fire, .period_mon, .auto_trig, .trig_out, .smp_valid,
		.smp_data, .smp_out_valid, .smp_out_data, .ts_valid, .ts_data, .ts_last);
	atl_far_end atl_far_end_inst (.ref_clk, .sys_rst, .ts_valid, .ts_data, .ts_last,
		.n_words, .n_pkts, .snap);

	initial begin
		ref_clk = 0;
		forever #2 ref_clk = ~ref_clk;
	end

	task chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task give_verdict;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask

	function logic [15:0] lf(int i);
		return 16'(i * 37 ^ 16'h5a3c);
	endfunction

	task next_auto(output int g);
		g = 0;
		do begin
			@(posedge ref_clk);
			g++;
		end while (auto_trig !== 1'b1 && g < 200);
	endtask

	task run_smp(input bit lut);
		logic [9:0] s, c;
		for (int k = 0; k < 66; k++) begin
			@(posedge ref_clk);
			if (smp_out_valid === 1'b1) chk("sample", smp_out_data, q.pop_front());
			s = k == 0 ? 10'h3ff : 10'($urandom_range(0, 1023));
			c = s + 10'h5;
			smp_valid <= k < 60;
			smp_data <= s;
			if (k < 60) q.push_back(lut ? lf(c) : {6'h0, c});
		end
		chk("samples left", q.size(), 0);
	endtask

	initial begin
		void'($urandom(32'h56c79460));
		{sys_rst, reg_wr, reg_rd, period_mon, smp_valid} = 5'h10;
		{reg_addr, reg_wdata, src_level, src_fire, smp_data} = 0;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 0;
		wr(REG_FIXED_DLY, 3);
		wr(REG_SPREAD, 0);
		wr(REG_TRIG_MASK, 0);
		wr(REG_CTRL, 1);
		next_auto(gap);
		repeat (3) begin
			next_auto(gap);
			chk("auto gap", gap, 5);
		end
		{na, nt} = 0;
		repeat (42) begin
			@(posedge ref_clk);
			na += auto_trig;
			nt += trig_out;
		end
		chk("auto count", na, 8);
		chk("trig count", nt, na);
		wr(REG_SPREAD, 2);
		next_auto(gap);
		repeat (20) begin
			next_auto(gap);
			chk("spread gap", gap inside {[5:8]}, 1);
		end
		wr(REG_CTRL, 0);
		repeat (4) @(posedge ref_clk);
		na = 0;
		repeat (30) begin
			@(posedge ref_clk);
			na += auto_trig;
		end
		chk("auto off", na, 0);
		wr(REG_SPREAD, 32'h0000_001f);
		rd(REG_SPREAD, v);
		chk("spread clip", v, 32'(SPREAD_MAX));
		wr(REG_LUT_ADDR, 0);
		for (int i = 0; i < LUT_DEPTH; i++) wr(REG_LUT_DATA, lf(i));
		wr(REG_INL_OFS, 5);
		wr(REG_CTRL, 2);
		run_smp(1);
		wr(REG_CTRL, 0);
		run_smp(0);
		wr(REG_TS_MASK, 32'h0000_00f0);
		wr(REG_CTRL, 4);
		for (int t = 0; t < 3; t++) begin
			lvl = $urandom;
			@(posedge ref_clk);
			src_level <= lvl;
			src_fire <= t == 2 ? 32'h0000_0100 : 32'h0000_00f0 & ($urandom | 32'h30);
			@(posedge ref_clk);
			src_fire <= 0;
			repeat (10) @(posedge ref_clk);
			chk("packets", n_pkts, t < 2 ? t + 1 : 2);
			chk("words", n_words, t < 2 ? 4 * t + 4 : 8);
			if (t < 2) chk("snapshot", snap, lvl);
		end
		rd(REG_STATUS, v);
		chk("status", v, 2);
		rd(8'h40, v);
		chk("unmapped", v, 0);
		give_verdict;
	end

	initial begin
		#60000;
		n_errors++;
		give_verdict;
	end
endmodule
